//--- core/output_config_pkg.sv
// Package with the register map, field layout and carriers of the output configuration bank.
package output_config_pkg;

  // Register indices; the APB byte address is four times the index.
  localparam logic [7:0] CLK_IDX [10] = '{8'h24, 8'h25, 8'h26, 8'h34, 8'h35,
                                         8'h44, 8'h45, 8'h54, 8'h64, 8'h65};
  localparam logic [7:0] REF_DELAY_IDX [8] = '{8'h28, 8'h29, 8'h2A, 8'h38,
                                              8'h39, 8'h48, 8'h49, 8'h58};
  localparam logic [7:0] REF_DRIVE_IDX [8] = '{8'h2C, 8'h2D, 8'h2E, 8'h3C,
                                              8'h3D, 8'h4C, 8'h4D, 8'h5C};
  localparam logic [7:0] CLK_GATE_LO_IDX = 8'h74;
  localparam logic [7:0] CLK_GATE_HI_IDX = 8'h75;
  localparam logic [7:0] REF_GATE_IDX = 8'h76;

  // Counts of outputs.
  localparam int NUM_CLK = 10;
  localparam int NUM_REF = 8;

  // Writable bit masks; every other bit is reserved and reads zero.
  localparam logic [7:0] CLK_MASK = 8'h9C;
  localparam logic [7:0] DELAY_MASK = 8'h7F;
  localparam logic [7:0] DRIVE_MASK = 8'hBC;
  localparam logic [7:0] GATE_LO_MASK = 8'hFF;
  localparam logic [7:0] GATE_HI_MASK = 8'h03;

  // Reset values; the source select of a delay register comes up set.
  localparam logic [7:0] CLK_RESET = 8'h00;
  localparam logic [7:0] DELAY_RESET = 8'h10;
  localparam logic [7:0] DRIVE_RESET = 8'h00;
  localparam logic [7:0] GATE_RESET = 8'h00;

  // Field positions shared by the clock and drive registers; the bias bit exists in the drive register only.
  localparam int PD_BIT = 7;
  localparam int BIAS_BIT = 5;
  localparam int FMT_BIT = 4;
  localparam int SWING_HI = 3;
  localparam int SWING_LO = 2;

  // Field positions of the delay register.
  localparam int FINE_HI = 6;
  localparam int FINE_LO = 5;
  localparam int SRC_BIT = 4;
  localparam int COARSE_HI = 3;
  localparam int COARSE_LO = 1;
  localparam int FINE_TOP_BIT = 0;

  // Coarse delay step of one code, in picoseconds.
  localparam int COARSE_STEP_PS = 254;

  // Address geometry of the APB slave.
  localparam int ADDR_W = 12;
  localparam int IDX_LO = 2;
  localparam int IDX_HI = 9;

  // Settings of one clock output.
  typedef struct packed {
    logic power_down;
    logic format;
    logic [1:0] swing;
    logic enable;
  } clock_cfg_s;

  // Settings of one SYSREF output.
  typedef struct packed {
    logic source_select;
    logic [2:0] coarse_delay;
    logic [2:0] fine_delay;
    logic power_down;
    logic bias_request;
    logic format;
    logic [1:0] swing;
    logic enable;
  } sysref_cfg_s;

endpackage

//--- core/clock_output_slot.sv
// One clock output's swing, format and power register.
`timescale 1ns/1ps
`default_nettype none
module clock_output_slot (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Register access.
  input wire logic write_en,
  input wire logic [7:0] write_data,
  output logic [7:0] read_data,
  // Enable bit held in the shared gate register.
  input wire logic gate,
  // Decoded settings.
  output output_config_pkg::clock_cfg_s cfg
);

  // Stored register with reserved bits kept at zero.
  logic [7:0] slot_reg;

  // Register update; reserved bits never store a one.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      slot_reg <= output_config_pkg::CLK_RESET;
    end else if (write_en) begin
      slot_reg <= write_data & output_config_pkg::CLK_MASK;
    end
  end

  // Read back and field split.
  assign read_data = slot_reg;
  assign cfg.power_down = slot_reg[output_config_pkg::PD_BIT];
  assign cfg.format = slot_reg[output_config_pkg::FMT_BIT];
  assign cfg.swing = slot_reg[output_config_pkg::SWING_HI:output_config_pkg::SWING_LO];
  assign cfg.enable = gate;

endmodule
`default_nettype wire

//--- core/sysref_output_slot.sv
// One SYSREF output's delay register and drive register.
`timescale 1ns/1ps
`default_nettype none
module sysref_output_slot (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Register access.
  input wire logic delay_write_en,
  input wire logic drive_write_en,
  input wire logic [7:0] write_data,
  output logic [7:0] delay_read_data,
  output logic [7:0] drive_read_data,
  // Enable bit held in the shared gate register.
  input wire logic gate,
  // Decoded settings.
  output output_config_pkg::sysref_cfg_s cfg
);

  // Stored registers with reserved bits kept at zero.
  logic [7:0] delay_reg;
  logic [7:0] drive_reg;

  // Register update; each register has its own strobe.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      delay_reg <= output_config_pkg::DELAY_RESET;
      drive_reg <= output_config_pkg::DRIVE_RESET;
    end else begin
      if (delay_write_en) begin
        delay_reg <= write_data & output_config_pkg::DELAY_MASK;
      end
      if (drive_write_en) begin
        drive_reg <= write_data & output_config_pkg::DRIVE_MASK;
      end
    end
  end

  // Read back and field split.
  assign delay_read_data = delay_reg;
  assign drive_read_data = drive_reg;
  assign cfg.source_select = delay_reg[output_config_pkg::SRC_BIT];
  assign cfg.coarse_delay = delay_reg[output_config_pkg::COARSE_HI:output_config_pkg::COARSE_LO];
  assign cfg.fine_delay = {delay_reg[output_config_pkg::FINE_TOP_BIT],
                           delay_reg[output_config_pkg::FINE_HI:output_config_pkg::FINE_LO]};
  assign cfg.power_down = drive_reg[output_config_pkg::PD_BIT];
  assign cfg.bias_request = drive_reg[output_config_pkg::BIAS_BIT];
  assign cfg.format = drive_reg[output_config_pkg::FMT_BIT];
  assign cfg.swing = drive_reg[output_config_pkg::SWING_HI:output_config_pkg::SWING_LO];
  assign cfg.enable = gate;

endmodule
`default_nettype wire

//--- core/output_config_regs.sv
// APB register bank for the clock and SYSREF output configuration.
//
// Function
// - Clock swing code selects 250 to 1000mV.
// - Clock format bit selects LVDS or LVPECL.
// - Clock enable low holds output static low.
// - Ten clock outputs, each with own fields.
// - SYSREF fields exist for eight outputs only.
// - SYSREF registers hold delay, source, power, format, amplitude.
// - Delay register bit layout as specified.
// - Drive register bit layout as specified.
// - Shared register holds eight SYSREF enables.
// - Source select: own clock or central SYSREF.
// - Coarse delay adds value times 254ps.
// - SYSREF enable low holds output low.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module output_config_regs (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Decoded settings of every output.
  output output_config_pkg::clock_cfg_s [9:0] clock_output_cfg,
  output output_config_pkg::sysref_cfg_s [7:0] sysref_output_cfg,
  // Outputs that are allowed to toggle.
  output logic [9:0] clock_output_live,
  output logic [7:0] sysref_output_live
);

  // Bus flops.
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // Shared enable registers.
  logic [7:0] clk_gate_lo_reg;
  logic [7:0] clk_gate_hi_reg;
  logic [7:0] ref_gate_reg;

  // Live flags, registered so the ports come from flops.
  logic [9:0] clk_live_reg;
  logic [7:0] ref_live_reg;

  // Decoded address and phases.
  wire logic [7:0] idx = paddr[output_config_pkg::IDX_HI:output_config_pkg::IDX_LO];
  wire logic addr_clean = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  wire logic setup_phase = psel && !penable;
  wire logic write_edge = psel && penable && pready_reg && pwrite && pstrb[0];

  // Per-slot hits, strobes and masked read data.
  logic [9:0] clk_hit;
  logic [7:0] delay_hit;
  logic [7:0] drive_hit;
  logic [7:0] clk_rdata [10];
  logic [7:0] delay_rdata [8];
  logic [7:0] drive_rdata [8];
  logic [9:0] clk_gate;
  output_config_pkg::clock_cfg_s [9:0] clk_cfg;
  output_config_pkg::sysref_cfg_s [7:0] ref_cfg;

  // Hits on the shared registers.
  wire logic gate_lo_hit = addr_clean && (idx == output_config_pkg::CLK_GATE_LO_IDX);
  wire logic gate_hi_hit = addr_clean && (idx == output_config_pkg::CLK_GATE_HI_IDX);
  wire logic ref_gate_hit = addr_clean && (idx == output_config_pkg::REF_GATE_IDX);

  // Clock enables: first eight from the low register, msb first; E0 and E1 from the high one.
  assign clk_gate[8] = clk_gate_hi_reg[0];
  assign clk_gate[9] = clk_gate_hi_reg[1];

  // One slot per clock output.
  genvar gi;
  generate
    for (gi = 0; gi < output_config_pkg::NUM_CLK; gi++) begin : g_clk
      assign clk_hit[gi] = addr_clean && (idx == output_config_pkg::CLK_IDX[gi]);
      if (gi < 8) begin : g_lo
        assign clk_gate[gi] = clk_gate_lo_reg[7 - gi];
      end
      // Each clock output has independent fields.
      clock_output_slot u_slot (
        .clock(clock),
        .sys_rst(sys_rst),
        .write_en(write_edge && clk_hit[gi]),
        .write_data(pwdata[7:0]),
        .read_data(clk_rdata[gi]),
        .gate(clk_gate[gi]),
        .cfg(clk_cfg[gi])
      );
    end
  endgenerate

  // One slot per SYSREF output; channel E has none.
  generate
    for (gi = 0; gi < output_config_pkg::NUM_REF; gi++) begin : g_ref
      assign delay_hit[gi] = addr_clean && (idx == output_config_pkg::REF_DELAY_IDX[gi]);
      assign drive_hit[gi] = addr_clean && (idx == output_config_pkg::REF_DRIVE_IDX[gi]);
      // The two registers carry delay, source, power, format and amplitude.
      sysref_output_slot u_slot (
        .clock(clock),
        .sys_rst(sys_rst),
        .delay_write_en(write_edge && delay_hit[gi]),
        .drive_write_en(write_edge && drive_hit[gi]),
        .write_data(pwdata[7:0]),
        .delay_read_data(delay_rdata[gi]),
        .drive_read_data(drive_rdata[gi]),
        .gate(ref_gate_reg[7 - gi]),
        .cfg(ref_cfg[gi])
      );
    end
  endgenerate

  // Any known register at all.
  wire logic mapped = (|clk_hit) || (|delay_hit) || (|drive_hit) ||
                      gate_lo_hit || gate_hi_hit || ref_gate_hit;

  // Read selection: OR of every register masked by its hit.
  logic [7:0] read_sel;
  always_comb begin
    read_sel = 8'h00;
    // Slot registers.
    for (int i = 0; i < output_config_pkg::NUM_CLK; i++) begin
      read_sel = read_sel | (clk_rdata[i] & {8{clk_hit[i]}});
    end
    for (int i = 0; i < output_config_pkg::NUM_REF; i++) begin
      read_sel = read_sel | (delay_rdata[i] & {8{delay_hit[i]}});
      read_sel = read_sel | (drive_rdata[i] & {8{drive_hit[i]}});
    end
    // Shared enable registers.
    read_sel = read_sel | (clk_gate_lo_reg & {8{gate_lo_hit}});
    read_sel = read_sel | (clk_gate_hi_reg & {8{gate_hi_hit}});
    read_sel = read_sel | (ref_gate_reg & {8{ref_gate_hit}});
  end

  // APB answer: data and status are prepared in the setup cycle, ready in the first access cycle.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase && !mapped;
      // Upper bits read zero; a write phase returns zero.
      prdata_reg <= (setup_phase && !pwrite) ? {24'h00_0000, read_sel} : 32'h0000_0000;
    end
  end

  // Shared enable registers; all enables come up off.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      clk_gate_lo_reg <= output_config_pkg::GATE_RESET;
      clk_gate_hi_reg <= output_config_pkg::GATE_RESET;
      ref_gate_reg <= output_config_pkg::GATE_RESET;
    end else if (write_edge) begin
      // Only the byte at the decoded index changes.
      if (gate_lo_hit) begin
        clk_gate_lo_reg <= pwdata[7:0] & output_config_pkg::GATE_LO_MASK;
      end
      if (gate_hi_hit) begin
        clk_gate_hi_reg <= pwdata[7:0] & output_config_pkg::GATE_HI_MASK;
      end
      if (ref_gate_hit) begin
        ref_gate_reg <= pwdata[7:0];
      end
    end
  end

  // Live flags: an output toggles only when enabled and powered up.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      clk_live_reg <= 10'h000;
      ref_live_reg <= 8'h00;
    end else begin
      for (int i = 0; i < output_config_pkg::NUM_CLK; i++) begin
        clk_live_reg[i] <= clk_cfg[i].enable && !clk_cfg[i].power_down;
      end
      for (int i = 0; i < output_config_pkg::NUM_REF; i++) begin
        // Power-down wins over the enable.
        ref_live_reg[i] <= ref_cfg[i].enable && !ref_cfg[i].power_down;
      end
    end
  end

  // Ports driven from flops.
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign clock_output_cfg = clk_cfg;
  assign sysref_output_cfg = ref_cfg;
  assign clock_output_live = clk_live_reg;
  assign sysref_output_live = ref_live_reg;

  // Byte addresses used by the checks below.
  wire logic [11:0] clk0_addr = {2'h0, output_config_pkg::CLK_IDX[0], 2'h0};
  wire logic [11:0] delay0_addr = {2'h0, output_config_pkg::REF_DELAY_IDX[0], 2'h0};
  wire logic [11:0] drive0_addr = {2'h0, output_config_pkg::REF_DRIVE_IDX[0], 2'h0};
  wire logic [11:0] gate_addr = {2'h0, output_config_pkg::REF_GATE_IDX, 2'h0};
  wire logic wr_done = psel && penable && pready && pwrite && pstrb[0];
  wire logic [11:0] gate_lo_addr = {2'h0, output_config_pkg::CLK_GATE_LO_IDX, 2'h0};
  wire logic [11:0] gate_hi_addr = {2'h0, output_config_pkg::CLK_GATE_HI_IDX, 2'h0};

  // A write to the first clock slot sets its swing.
  property p_clk_swing;
    @(posedge clock) disable iff (sys_rst)
    (wr_done && paddr == clk0_addr) |=> (clock_output_cfg[0].swing == $past(pwdata[3:2]));
  endproperty
  a_clk_swing: assert property (p_clk_swing) else $error("clock swing not stored");

  // A write to the first clock slot sets its format.
  property p_clk_format;
    @(posedge clock) disable iff (sys_rst)
    (wr_done && paddr == clk0_addr) |=> (clock_output_cfg[0].format == $past(pwdata[4]));
  endproperty
  a_clk_format: assert property (p_clk_format) else $error("clock format not stored");

  // A disabled clock output is not live one cycle later.
  property p_clk_off;
    @(posedge clock) disable iff (sys_rst)
    !clock_output_cfg[9].enable |=> !clock_output_live[9];
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("disabled clock output live");

  // The would-be SYSREF E register is unmapped and errors.
  property p_no_ref_e;
    @(posedge clock) disable iff (sys_rst)
    (psel && !penable && paddr == 12'h1A0) |=> (pready && pslverr);
  endproperty
  a_no_ref_e: assert property (p_no_ref_e) else $error("SYSREF E access not refused");

  // Delay register fields land at their bit positions.
  property p_delay_layout;
    @(posedge clock) disable iff (sys_rst)
    (wr_done && paddr == delay0_addr) |=>
      (sysref_output_cfg[0].fine_delay == {$past(pwdata[0]), $past(pwdata[6:5])}) &&
      (sysref_output_cfg[0].coarse_delay == $past(pwdata[3:1])) &&
      (sysref_output_cfg[0].source_select == $past(pwdata[4]));
  endproperty
  a_delay_layout: assert property (p_delay_layout) else $error("delay layout wrong");

  // Drive register fields land at their bit positions.
  property p_drive_layout;
    @(posedge clock) disable iff (sys_rst)
    (wr_done && paddr == drive0_addr) |=>
      (sysref_output_cfg[0].power_down == $past(pwdata[7])) &&
      (sysref_output_cfg[0].bias_request == $past(pwdata[5])) &&
      (sysref_output_cfg[0].swing == $past(pwdata[3:2]));
  endproperty
  a_drive_layout: assert property (p_drive_layout) else $error("drive layout wrong");

  // Bit 7 of the gate register enables A0 and bit 0 enables D.
  property p_gate_map;
    @(posedge clock) disable iff (sys_rst)
    (wr_done && paddr == gate_addr) |=>
      (sysref_output_cfg[0].enable == $past(pwdata[7])) &&
      (sysref_output_cfg[7].enable == $past(pwdata[0]));
  endproperty
  a_gate_map: assert property (p_gate_map) else $error("SYSREF enable map wrong");

  // A SYSREF output powered down for two cycles is not live in the next cycle.
  property p_pd_off;
    @(posedge clock) disable iff (sys_rst)
    sysref_output_cfg[3].power_down [*2] |=> !sysref_output_live[3];
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("powered-down SYSREF live");

  // Reserved bit 7 of a delay register reads zero.
  property p_reserved_zero;
    @(posedge clock) disable iff (sys_rst)
    (psel && !penable && !pwrite && paddr == delay0_addr) |=> (prdata[31:7] == 25'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  // Bit 7 of the low clock enable register drives A0 and bit 0 drives D.
  property p_clk_gate_lo;
    @(posedge clock) disable iff (sys_rst)
    (wr_done && paddr == gate_lo_addr) |=>
      (clock_output_cfg[0].enable == $past(pwdata[7])) &&
      (clock_output_cfg[7].enable == $past(pwdata[0]));
  endproperty
  a_clk_gate_lo: assert property (p_clk_gate_lo) else $error("clock enable map wrong");

  // E0 and E1 take their enables from the two low bits of the high register.
  property p_clk_gate_hi;
    @(posedge clock) disable iff (sys_rst)
    (wr_done && paddr == gate_hi_addr) |=>
      (clock_output_cfg[8].enable == $past(pwdata[0])) &&
      (clock_output_cfg[9].enable == $past(pwdata[1]));
  endproperty
  a_clk_gate_hi: assert property (p_clk_gate_hi) else $error("E clock enable map wrong");

  // An enabled, powered-up SYSREF output is live one cycle later.
  property p_ref_on;
    @(posedge clock) disable iff (sys_rst)
    (sysref_output_cfg[0].enable && !sysref_output_cfg[0].power_down) |=>
      sysref_output_live[0];
  endproperty
  a_ref_on: assert property (p_ref_on) else $error("enabled SYSREF output not live");

  // A disabled SYSREF output is held low.
  property p_ref_off;
    @(posedge clock) disable iff (sys_rst)
    !sysref_output_cfg[7].enable |=> !sysref_output_live[7];
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("disabled SYSREF output live");

  // A refused write leaves every setting as it was.
  property p_refused_write;
    @(posedge clock) disable iff (sys_rst)
    (wr_done && pslverr) |=> ($stable(clock_output_cfg) && $stable(sysref_output_cfg));
  endproperty
  a_refused_write: assert property (p_refused_write) else $error("refused write stored");

  // An unmapped read answers with an error and zero data.
  property p_hole_read;
    @(posedge clock) disable iff (sys_rst)
    (psel && !penable && !pwrite && !mapped) |=> (pslverr && prdata == 32'h0000_0000);
  endproperty
  a_hole_read: assert property (p_hole_read) else $error("unmapped read not refused");

  // Reserved bits 6 and 1:0 of a drive register read zero.
  property p_drive_reserved;
    @(posedge clock) disable iff (sys_rst)
    (psel && !penable && !pwrite && paddr == drive0_addr) |=>
      (prdata[6] == 1'b0) && (prdata[1:0] == 2'h0);
  endproperty
  a_drive_reserved: assert property (p_drive_reserved) else $error("drive reserved set");

  // Main scenarios.
  c_ref_write: cover property (@(posedge clock) disable iff (sys_rst)
    wr_done && paddr == drive0_addr);
  c_ref_live: cover property (@(posedge clock) disable iff (sys_rst) sysref_output_live[0]);
  c_unmapped: cover property (@(posedge clock) disable iff (sys_rst) pready && pslverr);
  c_clk_live: cover property (@(posedge clock) disable iff (sys_rst) clock_output_live[9]);
  c_strobe_off: cover property (@(posedge clock) disable iff (sys_rst)
    psel && penable && pready && pwrite && !pstrb[0]);

endmodule
`default_nettype wire

//--- dv/output_stage_model.sv
// Model of the output stages and of the converters that watch their pins.
`timescale 1ns/1ps
`default_nettype none
module output_stage_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Outputs that are allowed to toggle.
  input wire logic [9:0] clock_live,
  input wire logic [7:0] sysref_live,
  // Pin levels seen by the converters.
  output logic [9:0] clock_pins,
  output logic [7:0] sysref_pins
);
  // A live output toggles every cycle; a gated or powered-down one sits at static low.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      clock_pins <= 10'h000;
      sysref_pins <= 8'h00;
    end else begin
      clock_pins <= clock_live & ~clock_pins;
      sysref_pins <= sysref_live & ~sysref_pins;
    end
  end
endmodule
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench of the output configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // Clock, reset and APB request.
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  // Answers, settings and pins.
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  output_config_pkg::clock_cfg_s [9:0] ccfg;
  output_config_pkg::sysref_cfg_s [7:0] rcfg;
  logic [9:0] clive;
  logic [7:0] rlive;
  logic [9:0] cpin;
  logic [7:0] rpin;
  // Run counters and the last answer taken.
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] rd;
  logic err;

  // The clock inverts every half period of 2 ns.
  always #2 clock = ~clock;

  output_config_regs uut (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_output_cfg(ccfg), .sysref_output_cfg(rcfg),
    .clock_output_live(clive), .sysref_output_live(rlive)
  );

  output_stage_model partner (
    .clock(clock), .sys_rst(sys_rst), .clock_live(clive),
    .sysref_live(rlive), .clock_pins(cpin), .sysref_pins(rpin)
  );

  // Prints the verdict and stops.
  task automatic end_of_test;
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Compares one value and reports a difference.
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic [7:0] idx, input logic [1:0] low, input logic w,
                     input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, low};
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    // The access phase lasts until pready is seen high at a rising edge.
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Writes one register at its aligned word.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(idx, 2'h0, 1'b1, d);
  endtask

  // Reads one register and checks value and error flag.
  task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    apb(idx, 2'h0, 1'b0, 8'h00);
    chk(what, {2'h0, exp}, {2'h0, rd});
    chk("read error", 10'h000, {9'h000, err});
  endtask

  // Waits for the live outputs to settle, then checks them and the pin activity.
  task automatic settle_chk(input logic ref_side, input logic [9:0] exp);
    logic [9:0] p;
    repeat (3) @(negedge clock);
    p = ref_side ? {2'h0, rpin} : cpin;
    chk("live", exp, ref_side ? {2'h0, rlive} : clive);
    chk("pin low", 10'h000, p & ~exp);
    @(negedge clock);
    chk("pin toggle", exp, p ^ (ref_side ? {2'h0, rpin} : cpin));
  endtask

  // Reset values of every slot register and the SYSREF enables, the source selects and the clock live flags.
  task automatic t_reset;
    for (int k = 0; k < 10; k++) begin
      rdchk("clock reg", output_config_pkg::CLK_IDX[k], 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      rdchk("delay reg", output_config_pkg::REF_DELAY_IDX[i], 8'h10);
      rdchk("drive reg", output_config_pkg::REF_DRIVE_IDX[i], 8'h00);
      chk("source", 10'h001, {9'h000, rcfg[i].source_select});
    end
    rdchk("ref enables", 8'h76, 8'h00);
    settle_chk(1'b0, 10'h000);
  endtask

  // Reserved bits read zero; a write without the low strobe is dropped.
  task automatic t_masks;
    logic [7:0] a;
    for (int i = 0; i < 8; i++) begin
      a = output_config_pkg::REF_DELAY_IDX[i];
      wr(a, 8'hFF);
      rdchk("delay mask", a, 8'h7F);
      a = output_config_pkg::REF_DRIVE_IDX[i];
      wr(a, 8'hFF);
      rdchk("drive mask", a, 8'hBC);
    end
    for (int k = 0; k < 10; k++) begin
      a = output_config_pkg::CLK_IDX[k];
      wr(a, 8'hFF);
      rdchk("clock mask", a, 8'h9C);
      wr(a, 8'h00);
    end
    wr(8'h75, 8'hFF);
    rdchk("gate hi mask", 8'h75, 8'h03);
    wr(8'h76, 8'hFF);
    pstrb <= 4'hE;
    wr(8'h76, 8'h00);
    pstrb <= 4'hF;
    rdchk("strobe off", 8'h76, 8'hFF);
    wr(8'h75, 8'h00);
    wr(8'h76, 8'h00);
  endtask

  // Delay and drive fields land in the right settings of each output.
  task automatic t_fields;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 2; j++) begin
        v = j ? 8'h32 : 8'h4D;
        wr(output_config_pkg::REF_DELAY_IDX[i], v);
        @(negedge clock);
        chk("delay fields", {3'h0, v[4], v[3:1], v[0], v[6:5]},
            {3'h0, rcfg[i].source_select, rcfg[i].coarse_delay, rcfg[i].fine_delay});
        v = j ? 8'h34 : 8'hA8;
        wr(output_config_pkg::REF_DRIVE_IDX[i], v);
        @(negedge clock);
        chk("drive fields", {5'h00, v[7], v[5:2]}, {5'h00, rcfg[i].power_down,
            rcfg[i].bias_request, rcfg[i].format, rcfg[i].swing});
      end
    end
  endtask

  // Each shared enable bit opens one SYSREF output; power-down overrides it.
  task automatic t_ref_en;
    for (int i = 0; i < 8; i++) begin
      wr(8'h76, 8'h80 >> i);
      settle_chk(1'b1, 10'h001 << i);
      wr(output_config_pkg::REF_DRIVE_IDX[i], 8'h80);
      settle_chk(1'b1, 10'h000);
      wr(output_config_pkg::REF_DRIVE_IDX[i], 8'h00);
    end
    wr(8'h76, 8'h00);
  endtask

  // Every swing and format code on every clock output, then its enable.
  task automatic t_clk;
    logic [7:0] v;
    for (int k = 0; k < 10; k++) begin
      for (int c = 0; c < 8; c++) begin
        v = {3'h0, c[2:0], 2'h0};
        wr(output_config_pkg::CLK_IDX[k], v);
        @(negedge clock);
        chk("clock fields", {7'h00, v[4:2]}, {7'h00, ccfg[k].format, ccfg[k].swing});
      end
      wr(8'h74, k < 8 ? 8'h80 >> k : 8'h00);
      wr(8'h75, k < 8 ? 8'h00 : 8'h01 << (k - 8));
      settle_chk(1'b0, 10'h001 << k);
      wr(output_config_pkg::CLK_IDX[k], 8'h80);
      settle_chk(1'b0, 10'h000);
      wr(output_config_pkg::CLK_IDX[k], 8'h00);
    end
  endtask

  // Holes, a missing channel E SYSREF place and a misaligned write.
  task automatic t_unmapped;
    apb(8'h27, 2'h0, 1'b0, 8'h00);
    chk("hole error", 10'h001, {9'h000, err});
    chk("hole data", 10'h000, {2'h0, rd});
    apb(8'h68, 2'h0, 1'b1, 8'hFF);
    chk("no E sysref", 10'h001, {9'h000, err});
    apb(8'h28, 2'h1, 1'b1, 8'h00);
    chk("misaligned", 10'h001, {9'h000, err});
    rdchk("delay kept", 8'h28, 8'h32);
  endtask

  // Cuts a hang short.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      n_fail++;
      end_of_test();
    end
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_masks();
    t_fields();
    t_ref_en();
    t_clk();
    t_unmapped();
    end_of_test();
  end
endmodule
`default_nettype wire
